// ==== logic/cdo_consts.svh ====
// offsets, field positions, reset values, response codes and step values for the op executor
`ifndef CDO_CONSTS_SVH
`define CDO_CONSTS_SVH
`define CDO_ADDR_W 8
`define CDO_OFS_CTRL 8'h00
`define CDO_OFS_STATUS 8'h04
`define CDO_OFS_ACC 8'h08
`define CDO_OFS_PCLATCH 8'h0c
`define CDO_OFS_PC 8'h10
`define CDO_CTRL_EN_BIT 0
`define CDO_ST_ZERO_BIT 0
`define CDO_ST_EXPIRED_BIT 1
`define CDO_ST_SLEEP_BIT 2
`define CDO_ST_BUSY_BIT 3
`define CDO_RST_CTRL_EN 1'b1
`define CDO_RST_ACC 8'h00
`define CDO_RST_PCLATCH 7'h00
`define CDO_RST_PC 15'h0000
`define CDO_RST_ZERO 1'b0
`define CDO_RST_EXPIRED 1'b1
`define CDO_RST_SLEEP 1'b1
`define CDO_RESP_OKAY 2'h0
`define CDO_RESP_SLVERR 2'h2
`define CDO_PC_STEP 15'h0001
`define CDO_DEC_STEP 8'h01
`endif

// ==== logic/cdo_exec.sv ====
// executor for the clear, decrement, complement and call-through-accumulator ops
// Operation
// - watchdog clear resets counter and prescaler
// - watchdog clear sets expired and sleep flags
// - accumulator call pushes pc plus one
// - then pc gets latch and accumulator
// - accumulator call: two cycles, flags kept
// - complement file, routed by destination, updates zero
// - clear file writes zero, sets zero
// - decrement file, routed by destination, updates zero
// - clear accumulator writes zero, sets zero
// - decrement skip routes result, flags kept
// - zero result discards next, two cycles
// - file address 7 bits, destination one bit
`timescale 1ns/100ps
`include "cdo_consts.svh"
`default_nettype none
module cdo_exec (
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // op request
  input wire logic op_valid,
  output logic op_ready,
  input wire cdo_pkg::cdo_op_t op_code,
  input wire logic [6:0] op_file_addr,
  input wire logic op_dest_sel,
  input wire logic [7:0] op_file_data,
  // file register write
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  // return stack push
  output logic stack_push,
  output logic [14:0] stack_top,
  // watchdog and sequencing
  output logic watchdog_counter_clear,
  output logic watchdog_prescaler_clear,
  output logic skip_next,
  // core state
  output logic [7:0] acc,
  output logic [14:0] pc,
  output logic zero_flag,
  output logic watchdog_expired_flag,
  output logic sleep_entered_flag,
  // axi4-lite slave
  input wire logic [`CDO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CDO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // op decode and result
  logic take;
  logic two_cycle;
  logic busy;
  logic exec_en;
  logic [6:0] upper_pc_latch;
  logic [7:0] next_result;
  logic next_to_acc;
  logic next_to_file;
  logic next_zero_upd;
  logic next_zero;
  logic [14:0] next_pc;
  logic bus_wr;
  logic [`CDO_ADDR_W-1:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic aw_held;
  logic w_held;

  assign take = ce & op_valid & op_ready;

  always_comb begin
    next_result = 8'h00;
    next_to_acc = 1'b0;
    next_to_file = 1'b0;
    next_zero_upd = 1'b0;
    next_zero = zero_flag;
    two_cycle = 1'b0;
    next_pc = pc + `CDO_PC_STEP;
    unique case (op_code)
      cdo_pkg::cdo_call_via_accumulator_op: begin
        next_pc = {upper_pc_latch, acc};
        two_cycle = 1'b1;
      end
      cdo_pkg::cdo_complement_file_op: begin
        next_result = ~op_file_data;
        next_to_acc = ~op_dest_sel;
        next_to_file = op_dest_sel;
        next_zero_upd = 1'b1;
        next_zero = (next_result == 8'h00);
      end
      cdo_pkg::cdo_clear_file_op: begin
        next_to_file = 1'b1;
        next_zero_upd = 1'b1;
        next_zero = 1'b1;
      end
      cdo_pkg::cdo_decrement_file_op: begin
        next_result = op_file_data - `CDO_DEC_STEP;
        next_to_acc = ~op_dest_sel;
        next_to_file = op_dest_sel;
        next_zero_upd = 1'b1;
        next_zero = (next_result == 8'h00);
      end
      cdo_pkg::cdo_clear_accumulator_op: begin
        next_to_acc = 1'b1;
        next_zero_upd = 1'b1;
        next_zero = 1'b1;
      end
      cdo_pkg::cdo_decrement_skip_zero_op: begin
        next_result = op_file_data - `CDO_DEC_STEP;
        next_to_acc = ~op_dest_sel;
        next_to_file = op_dest_sel;
        two_cycle = (next_result == 8'h00);
        if (next_result == 8'h00) begin
          next_pc = pc + `CDO_PC_STEP + `CDO_PC_STEP;
        end
      end
      default: begin
        next_result = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // sequencing: acceptance and second cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      op_ready <= 1'b0;
    end else if (ce) begin
      if (take && two_cycle) begin
        busy <= 1'b1;
        op_ready <= 1'b0;
      end else begin
        busy <= 1'b0;
        op_ready <= exec_en;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc <= `CDO_RST_PC;
    end else if (ce && take) begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      skip_next <= 1'b0;
    end else if (ce) begin
      skip_next <= take && op_code == cdo_pkg::cdo_decrement_skip_zero_op
                   && next_result == 8'h00;
    end
  end

  // ==========================================================
  // file write and stack push
  always_ff @(posedge clk) begin
    if (srst) begin
      file_wr_en <= 1'b0;
      file_wr_addr <= 7'h00;
      file_wr_data <= 8'h00;
    end else if (ce) begin
      file_wr_en <= take & next_to_file;
      if (take && next_to_file) begin
        file_wr_addr <= op_file_addr;
        file_wr_data <= next_result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stack_push <= 1'b0;
      stack_top <= 15'h0000;
    end else if (ce) begin
      stack_push <= take && op_code == cdo_pkg::cdo_call_via_accumulator_op;
      if (take && op_code == cdo_pkg::cdo_call_via_accumulator_op) begin
        stack_top <= pc + `CDO_PC_STEP;
      end
    end
  end

  // ==========================================================
  // watchdog clear and status flags
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_counter_clear <= 1'b0;
      watchdog_prescaler_clear <= 1'b0;
    end else if (ce) begin
      watchdog_counter_clear <= take && op_code == cdo_pkg::cdo_clear_watchdog_op;
      watchdog_prescaler_clear <= take && op_code == cdo_pkg::cdo_clear_watchdog_op;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_expired_flag <= `CDO_RST_EXPIRED;
      sleep_entered_flag <= `CDO_RST_SLEEP;
    end else if (ce && take && op_code == cdo_pkg::cdo_clear_watchdog_op) begin
      watchdog_expired_flag <= 1'b1;
      sleep_entered_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zero_flag <= `CDO_RST_ZERO;
    end else if (ce && take && next_zero_upd) begin
      zero_flag <= next_zero;
    end
  end

  // ==========================================================
  // accumulator, op write wins over bus write
  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= `CDO_RST_ACC;
    end else if (ce) begin
      if (take && next_to_acc) begin
        acc <= next_result;
      end else if (bus_wr && wr_addr_q == `CDO_OFS_ACC && wr_strb_q[0]) begin
        acc <= wr_data_q[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      upper_pc_latch <= `CDO_RST_PCLATCH;
      exec_en <= `CDO_RST_CTRL_EN;
    end else if (ce && bus_wr && wr_strb_q[0]) begin
      if (wr_addr_q == `CDO_OFS_PCLATCH) begin
        upper_pc_latch <= wr_data_q[6:0];
      end
      if (wr_addr_q == `CDO_OFS_CTRL) begin
        exec_en <= wr_data_q[`CDO_CTRL_EN_BIT];
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  assign bus_wr = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CDO_RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (bus_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr_q == `CDO_OFS_CTRL || wr_addr_q == `CDO_OFS_STATUS ||
                        wr_addr_q == `CDO_OFS_ACC || wr_addr_q == `CDO_OFS_PCLATCH ||
                        wr_addr_q == `CDO_OFS_PC) ? `CDO_RESP_OKAY : `CDO_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CDO_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CDO_RESP_OKAY;
        unique case (s_axi_araddr)
          `CDO_OFS_CTRL: s_axi_rdata <= {31'h00000000, exec_en};
          `CDO_OFS_STATUS: s_axi_rdata <= {28'h0000000, busy, sleep_entered_flag,
                                           watchdog_expired_flag, zero_flag};
          `CDO_OFS_ACC: s_axi_rdata <= {24'h000000, acc};
          `CDO_OFS_PCLATCH: s_axi_rdata <= {25'h0000000, upper_pc_latch};
          `CDO_OFS_PC: s_axi_rdata <= {17'h00000, pc};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CDO_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : cdo_exec
`default_nettype wire

// ==== logic/cdo_pkg.sv ====
// types shared by the op executor
`default_nettype none
package cdo_pkg;
  typedef enum logic [2:0] {
    cdo_clear_watchdog_op = 3'h0,
    cdo_call_via_accumulator_op = 3'h1,
    cdo_complement_file_op = 3'h2,
    cdo_clear_file_op = 3'h3,
    cdo_decrement_file_op = 3'h4,
    cdo_clear_accumulator_op = 3'h5,
    cdo_decrement_skip_zero_op = 3'h6,
    cdo_nop_op = 3'h7
  } cdo_op_t;
endpackage : cdo_pkg
`default_nettype wire

// ==== verif/cdo_exec_chk.sv ====
// assertions on the op executor ports
`timescale 1ns/100ps
`default_nettype none
module cdo_exec_chk (
  // clock and request
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire cdo_pkg::cdo_op_t op_code,
  input wire logic op_dest_sel,
  input wire logic [7:0] op_file_data,
  // results
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data,
  input wire logic stack_push,
  input wire logic [14:0] stack_top,
  input wire logic watchdog_counter_clear,
  input wire logic watchdog_prescaler_clear,
  input wire logic skip_next,
  input wire logic [7:0] acc,
  input wire logic [14:0] pc,
  input wire logic zero_flag,
  input wire logic watchdog_expired_flag,
  input wire logic sleep_entered_flag
);
  logic tk;
  logic [2:0] fl;
  logic [7:0] fd;
  assign tk = ce && op_valid && op_ready;
  assign fl = {zero_flag, watchdog_expired_flag, sleep_entered_flag};
  assign fd = op_file_data;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========
  // op effects
  property p_wdt;
    tk && op_code == cdo_pkg::cdo_clear_watchdog_op |=> watchdog_counter_clear
      && watchdog_prescaler_clear && watchdog_expired_flag && sleep_entered_flag;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
  property p_push;
    tk && op_code == cdo_pkg::cdo_call_via_accumulator_op |=>
      stack_push && stack_top == $past(pc) + 15'h1;
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");
  property p_pcld;
    tk && op_code == cdo_pkg::cdo_call_via_accumulator_op |=> pc[7:0] == $past(acc);
  endproperty
  a_pcld: assert property (p_pcld) else $error("call target wrong");
  property p_call2;
    tk && op_code == cdo_pkg::cdo_call_via_accumulator_op |=>
      !op_ready && $stable(fl) ##1 op_ready;
  endproperty
  a_call2: assert property (p_call2) else $error("call timing wrong");
  property p_complement_file_op;
    tk && op_code == cdo_pkg::cdo_complement_file_op |=> file_wr_en == $past(op_dest_sel)
      && zero_flag == ($past(fd) == 8'hff) && (!file_wr_en || file_wr_data == ~$past(fd));
  endproperty
  a_complement_file_op: assert property (p_complement_file_op) else $error("complement wrong");
  property p_clear_file_op;
    tk && op_code == cdo_pkg::cdo_clear_file_op |=> file_wr_en && file_wr_data == 8'h00
      && zero_flag;
  endproperty
  a_clear_file_op: assert property (p_clear_file_op) else $error("clear file wrong");
  property p_decrement_file_op;
    tk && op_code == cdo_pkg::cdo_decrement_file_op |=> file_wr_en == $past(op_dest_sel)
      && zero_flag == ($past(fd) == 8'h01) && (file_wr_en || acc == $past(fd) - 8'h01);
  endproperty
  a_decrement_file_op: assert property (p_decrement_file_op) else $error("decrement wrong");
  property p_clear_accumulator_op;
    tk && op_code == cdo_pkg::cdo_clear_accumulator_op |=> acc == 8'h00 && zero_flag;
  endproperty
  a_clear_accumulator_op: assert property (p_clear_accumulator_op) else $error("clear acc wrong");
  property p_skip;
    tk && op_code == cdo_pkg::cdo_decrement_skip_zero_op |=>
      $stable(fl) && skip_next == ($past(fd) == 8'h01);
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
endmodule : cdo_exec_chk
bind cdo_exec cdo_exec_chk cdo_exec_chk_inst (.*);
`default_nettype wire

// ==== verif/cdo_exec_tb_top.sv ====
// self-checking bench for the op executor
`timescale 1ns/100ps
`include "cdo_consts.svh"
`default_nettype none
module cdo_exec_tb_top;
  typedef struct {
    cdo_pkg::cdo_op_t c;
    logic d;
    logic [7:0] f;
    logic [7:0] r;
  } cdo_row_t;
  logic clk = 1'h0, srst = 1'h1, ce = 1'h1, op_valid = 1'h0, op_dest_sel = 1'h0;
  cdo_pkg::cdo_op_t op_code = cdo_pkg::cdo_nop_op;
  logic [6:0] op_file_addr = 7'h7f;
  logic [7:0] op_file_data = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic op_ready, file_wr_en, stack_push, skip_next, zero_flag;
  logic watchdog_counter_clear, watchdog_prescaler_clear;
  logic watchdog_expired_flag, sleep_entered_flag;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0] file_wr_addr;
  logic [7:0] file_wr_data, acc;
  logic [14:0] stack_top, pc, p0;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] f0;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  cdo_row_t rows [6] = '{
    '{cdo_pkg::cdo_complement_file_op, 1'h0, 8'hff, 8'h00},
    '{cdo_pkg::cdo_complement_file_op, 1'h1, 8'h5a, 8'ha5},
    '{cdo_pkg::cdo_decrement_file_op, 1'h1, 8'h01, 8'h00},
    '{cdo_pkg::cdo_decrement_file_op, 1'h0, 8'h00, 8'hff},
    '{cdo_pkg::cdo_clear_file_op, 1'h1, 8'h3c, 8'h00},
    '{cdo_pkg::cdo_clear_accumulator_op, 1'h0, 8'h3c, 8'h00}};
  cdo_exec cdo_exec_inst (.*);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic op(input cdo_pkg::cdo_op_t c, input logic d, input logic [7:0] f);
    op_code <= c;
    op_dest_sel <= d;
    op_file_data <= f;
    op_valid <= 1'h1;
    do @(posedge clk); while (op_ready !== 1'h1);
    op_valid <= 1'h0;
    @(posedge clk);
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd_reg
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  // ==========
  // sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    chk({acc, pc, zero_flag, watchdog_expired_flag, sleep_entered_flag}, 26'h3);
    rd_reg(`CDO_OFS_STATUS);
    chk(rd, 32'h6);
    $display("test reset done");
    foreach (rows[i]) begin
      op_file_addr <= 7'h40 + 7'(i);
      op(rows[i].c, rows[i].d, rows[i].f);
      if (rows[i].d) chk(file_wr_addr, op_file_addr);
      chk(file_wr_en, rows[i].d);
      chk(rows[i].d ? file_wr_data : acc, rows[i].r);
      chk(zero_flag, rows[i].r == 8'h00);
    end
    $display("test rows done");
    wr(`CDO_OFS_ACC, 32'h34);
    wr(`CDO_OFS_PCLATCH, 32'h12);
    wr(8'h20, 32'h1);
    chk(rs, `CDO_RESP_SLVERR);
    rd_reg(8'h20);
    chk(rd, 32'h0);
    chk(rs, `CDO_RESP_SLVERR);
    wr(`CDO_OFS_CTRL, 32'h0);
    chk(op_ready, 1'h0);
    wr(`CDO_OFS_CTRL, 32'h1);
    chk({op_ready, rs}, {1'h1, `CDO_RESP_OKAY});
    rd_reg(`CDO_OFS_ACC);
    chk(rd, 32'h34);
    p0 = pc;
    op(cdo_pkg::cdo_call_via_accumulator_op, 1'h0, 8'h00);
    chk({stack_push, stack_top}, {1'h1, p0 + 15'h1});
    chk(pc, 15'h1234);
    chk(op_ready, 1'h0);
    $display("test call done");
    p0 = pc;
    f0 = {zero_flag, watchdog_expired_flag, sleep_entered_flag};
    op(cdo_pkg::cdo_decrement_skip_zero_op, 1'h1, 8'h01);
    chk({skip_next, file_wr_data, pc}, {1'h1, 8'h00, p0 + 15'h2});
    chk({zero_flag, watchdog_expired_flag, sleep_entered_flag}, f0);
    op(cdo_pkg::cdo_decrement_skip_zero_op, 1'h0, 8'h05);
    chk({skip_next, acc}, {1'h0, 8'h04});
    $display("test skip done");
    ce <= 1'h0;
    op_code <= cdo_pkg::cdo_clear_accumulator_op;
    op_valid <= 1'h1;
    repeat (3) @(posedge clk);
    chk({acc, pc, stack_push}, {8'h04, p0 + 15'h3, 1'h0});
    ce <= 1'h1;
    op(cdo_pkg::cdo_clear_accumulator_op, 1'h0, 8'h00);
    chk({acc, zero_flag}, {8'h00, 1'h1});
    $display("test enable done");
    op(cdo_pkg::cdo_clear_watchdog_op, 1'h0, 8'h00);
    chk({watchdog_counter_clear, watchdog_prescaler_clear}, 2'h3);
    chk({watchdog_expired_flag, sleep_entered_flag}, 2'h3);
    $display("test watchdog done");
    finish_test();
  end
endmodule : cdo_exec_tb_top
`default_nettype wire
